// *** core/rsp_pkg.sv ***
// Shared constants and types for the reset status and power-up timer block
package rsp_pkg;

	localparam int PC_BITS = 21;
	localparam int POWER_UP_TIMER_BITS = 11;
	localparam int CFG_WORDS = 8;
	localparam int CFG_BITS = 8;

	localparam logic [PC_BITS-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_BITS-1:0] PC_VEC_HIGH = 21'h000008;
	localparam logic [PC_BITS-1:0] PC_VEC_LOW = 21'h000018;
	localparam logic [PC_BITS-1:0] PC_STEP = 21'h000002;

	typedef enum logic [1:0]
	{
		PM_FULL = 2'b00,
		PM_RUN = 2'b01,
		PM_IDLE = 2'b10,
		PM_SLEEP = 2'b11
	} rsp_pmode_type;

	typedef enum logic [1:0]
	{
		ST_POWER = 2'b00,
		ST_TIMER = 2'b01,
		ST_HOLD = 2'b10,
		ST_RUN = 2'b11
	} rsp_state_type;

	// Flags are active low in meaning except the two stack flags
	typedef struct packed
	{
		logic cm;
		logic ri;
		logic to;
		logic pd;
		logic por;
		logic bor;
		logic stack_full_flag;
		logic stack_underflow_flag;
	} rsp_flags_type;

	typedef struct packed
	{
		logic reset_instr;
		logic wdt_timeout;
		logic stack_full;
		logic stack_underflow;
		logic irq_wake;
		logic clrwdt;
		logic sleep;
	} rsp_events_type;

	localparam rsp_flags_type FLAGS_POR = 8'hF0;
	// Status bits that software can write; the timeout and power-down bits are read only
	localparam rsp_flags_type FLAGS_SW_MASK = 8'hCF;

endpackage

// *** core/rsp_cfg_store.sv ***
// Configuration words with complementary shadow copies and mismatch detector
`timescale 1ns/1ps
module rsp_cfg_store #(
	parameter int WORDS = 8,
	parameter int BITS = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic reload_i,
	input wire logic [WORDS*BITS-1:0] flash_i,
	input wire logic [WORDS*BITS-1:0] upset_i,
	output logic [WORDS*BITS-1:0] words_o,
	output logic mismatch_o
);

	logic [WORDS-1:0] word_bad;
	logic [WORDS*BITS-1:0] live;

	genvar g;
	generate
		for (g = 0; g < WORDS; g++)
		begin : g_word
			logic [BITS-1:0] word_q;
			logic [BITS-1:0] shadow_q;
			// No reset: contents are unknown until the first reload
			always_ff @(posedge clk_i)
			begin
				if (reload_i)
				begin
					word_q <= flash_i[g*BITS +: BITS];
					shadow_q <= ~flash_i[g*BITS +: BITS];
				end
				else
				begin
					word_q <= word_q ^ upset_i[g*BITS +: BITS];
				end
			end
			assign word_bad[g] = (word_q != ~shadow_q);
			assign live[g*BITS +: BITS] = word_q;
		end
	endgenerate

	// One process owns the whole output word
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			words_o <= '0;
		else
			words_o <= live;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mismatch_o <= 1'b0;
		else
			mismatch_o <= (|word_bad) && !reload_i;
	end

endmodule

// *** core/rsp_top.sv ***
// Reset sequencer, reset status flags and power-up timer
`timescale 1ns/1ps
module rsp_top #(
	parameter int CFG_WORDS = rsp_pkg::CFG_WORDS,
	parameter int CFG_BITS = rsp_pkg::CFG_BITS,
	parameter int POWER_UP_TIMER_BITS = rsp_pkg::POWER_UP_TIMER_BITS
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic por_pulse_i,
	input wire logic brownout_pulse_i,
	input wire logic vreg_enable_i,
	input wire logic master_clear_pin_i,
	output logic master_clear_pin_o,
	output logic master_clear_pin_oe_o,
	input wire logic internal_rc_osc_tick_i,
	input wire rsp_pkg::rsp_pmode_type pmode_i,
	input wire rsp_pkg::rsp_events_type events_i,
	input wire logic stack_error_reset_enable_i,
	input wire logic global_irq_enable_high_i,
	input wire logic global_irq_enable_low_i,
	input wire logic irq_high_prio_i,
	input wire logic [rsp_pkg::PC_BITS-1:0] pc_i,
	input wire logic flag_wr_i,
	input wire rsp_pkg::rsp_flags_type flag_wr_data_i,
	input wire logic [CFG_WORDS*CFG_BITS-1:0] flash_cfg_i,
	input wire logic [CFG_WORDS*CFG_BITS-1:0] cfg_upset_i,
	output logic [CFG_WORDS*CFG_BITS-1:0] cfg_words_o,
	output logic cfg_reload_o,
	output logic core_reset_o,
	output logic power_up_timer_done_o,
	output rsp_pkg::rsp_flags_type reset_flags_o,
	output logic pc_load_o,
	output logic [rsp_pkg::PC_BITS-1:0] pc_value_o,
	output logic wake_o
);

	localparam logic [POWER_UP_TIMER_BITS-1:0] POWER_UP_TIMER_LAST = {POWER_UP_TIMER_BITS{1'b1}};

	rsp_pkg::rsp_state_type state_q;
	rsp_pkg::rsp_state_type state_d;
	logic [POWER_UP_TIMER_BITS-1:0] power_up_timer_cnt_q;
	logic power_up_timer_done_q;
	logic bor_act;
	logic power_act;
	logic running;
	logic sleepy;
	logic active_mode;
	logic master_clear_pin_low;
	logic cfg_mismatch;
	logic wdt_rst;
	logic stack_rst;
	logic hard_rst;
	logic wdt_wake;
	logic irq_wake;
	logic gie_any;

	assign bor_act = brownout_pulse_i && vreg_enable_i;
	assign power_act = por_pulse_i || bor_act;
	assign running = (state_q == rsp_pkg::ST_RUN);
	assign sleepy = (pmode_i == rsp_pkg::PM_IDLE) || (pmode_i == rsp_pkg::PM_SLEEP);
	assign active_mode = !sleepy;
	assign master_clear_pin_low = !master_clear_pin_i;
	assign wdt_rst = running && events_i.wdt_timeout && active_mode;
	assign wdt_wake = running && events_i.wdt_timeout && sleepy;
	assign irq_wake = running && events_i.irq_wake && sleepy;
	assign stack_rst = stack_error_reset_enable_i
		&& (events_i.stack_full || events_i.stack_underflow);
	// Underflow with the enable low falls out of this term on purpose
	assign hard_rst = running && (master_clear_pin_low || events_i.reset_instr || wdt_rst
		|| stack_rst || cfg_mismatch);
	assign gie_any = global_irq_enable_high_i || global_irq_enable_low_i;

	rsp_cfg_store #(
		.WORDS(CFG_WORDS),
		.BITS(CFG_BITS)
	) u_cfg (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.reload_i(cfg_reload_o),
		.flash_i(flash_cfg_i),
		.upset_i(cfg_upset_i),
		.words_o(cfg_words_o),
		.mismatch_o(cfg_mismatch)
	);

	// Sequencer; power events override everything, even mid-count
	always_comb
	begin
		state_d = state_q;
		if (power_act)
			state_d = rsp_pkg::ST_POWER;
		else
		begin
			case (state_q)
				rsp_pkg::ST_POWER:
					state_d = rsp_pkg::ST_TIMER;
				rsp_pkg::ST_TIMER:
				begin
					if (power_up_timer_done_q && master_clear_pin_i)
						state_d = rsp_pkg::ST_RUN;
					else if (power_up_timer_done_q)
						state_d = rsp_pkg::ST_HOLD;
				end
				rsp_pkg::ST_HOLD:
				begin
					if (master_clear_pin_i)
						state_d = rsp_pkg::ST_RUN;
				end
				rsp_pkg::ST_RUN:
				begin
					if (hard_rst)
						state_d = rsp_pkg::ST_HOLD;
				end
				default:
					state_d = rsp_pkg::ST_POWER;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_q <= rsp_pkg::ST_POWER;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			core_reset_o <= 1'b1;
		else
			core_reset_o <= (state_d != rsp_pkg::ST_RUN);
	end

	// Timer has no enable input at all: every power entry runs it
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			power_up_timer_cnt_q <= '0;
			power_up_timer_done_q <= 1'b0;
		end
		else if (power_act || state_q == rsp_pkg::ST_POWER)
		begin
			power_up_timer_cnt_q <= '0;
			power_up_timer_done_q <= 1'b0;
		end
		else if (internal_rc_osc_tick_i && !power_up_timer_done_q)
		begin
			if (power_up_timer_cnt_q == POWER_UP_TIMER_LAST)
				power_up_timer_done_q <= 1'b1;
			else
				power_up_timer_cnt_q <= power_up_timer_cnt_q + 1'b1;
		end
	end

	assign power_up_timer_done_o = power_up_timer_done_q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cfg_reload_o <= 1'b0;
		else
			cfg_reload_o <= (state_q == rsp_pkg::ST_POWER && !power_act) || hard_rst;
	end

	// Later assignments win, so hardware events beat a same-cycle software write
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			reset_flags_o <= rsp_pkg::FLAGS_POR;
		else
		begin
			if (flag_wr_i)
				reset_flags_o <= (reset_flags_o & ~rsp_pkg::FLAGS_SW_MASK)
					| (flag_wr_data_i & rsp_pkg::FLAGS_SW_MASK);
			if (running && events_i.clrwdt)
			begin
				reset_flags_o.to <= 1'b1;
				reset_flags_o.pd <= 1'b1;
			end
			if (running && events_i.sleep)
			begin
				reset_flags_o.to <= 1'b1;
				reset_flags_o.pd <= 1'b0;
			end
			if (running && cfg_mismatch)
				reset_flags_o.cm <= 1'b0;
			if (running && events_i.reset_instr)
				reset_flags_o.ri <= 1'b0;
			if (running && master_clear_pin_low && pmode_i == rsp_pkg::PM_RUN)
				reset_flags_o.to <= 1'b1;
			if (running && master_clear_pin_low && sleepy)
			begin
				reset_flags_o.to <= 1'b1;
				reset_flags_o.pd <= 1'b0;
			end
			if (wdt_rst)
				reset_flags_o.to <= 1'b0;
			if (wdt_wake)
			begin
				reset_flags_o.to <= 1'b0;
				reset_flags_o.pd <= 1'b0;
			end
			if (irq_wake)
				reset_flags_o.pd <= 1'b0;
			if (running && stack_error_reset_enable_i && events_i.stack_full)
				reset_flags_o.stack_full_flag <= 1'b1;
			if (running && events_i.stack_underflow)
				reset_flags_o.stack_underflow_flag <= 1'b1;
			if (bor_act)
			begin
				reset_flags_o.cm <= 1'b1;
				reset_flags_o.ri <= 1'b1;
				reset_flags_o.to <= 1'b1;
				reset_flags_o.pd <= 1'b1;
				reset_flags_o.bor <= 1'b0;
			end
			if (por_pulse_i)
				reset_flags_o <= rsp_pkg::FLAGS_POR;
		end
	end

	// Reset vector is loaded as the core comes out of reset
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pc_load_o <= 1'b0;
			pc_value_o <= rsp_pkg::PC_RESET;
			wake_o <= 1'b0;
		end
		else
		begin
			pc_load_o <= 1'b0;
			wake_o <= 1'b0;
			if (!running && state_d == rsp_pkg::ST_RUN)
			begin
				pc_load_o <= 1'b1;
				pc_value_o <= rsp_pkg::PC_RESET;
			end
			else if (!hard_rst && !power_act && (wdt_wake || irq_wake))
			begin
				pc_load_o <= 1'b1;
				wake_o <= 1'b1;
				if (irq_wake && !wdt_wake && gie_any)
					pc_value_o <= irq_high_prio_i ? rsp_pkg::PC_VEC_HIGH
						: rsp_pkg::PC_VEC_LOW;
				else
					pc_value_o <= pc_i + rsp_pkg::PC_STEP;
			end
		end
	end

	// Pin is input only; enable held low so no reset source can pull it
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			master_clear_pin_o <= 1'b0;
			master_clear_pin_oe_o <= 1'b0;
		end
		else
		begin
			master_clear_pin_o <= 1'b0;
			master_clear_pin_oe_o <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_bor_flag_clear: assert property (bor_act |=> !reset_flags_o.bor)
		else $error("brownout flag not cleared");
	a_vreg_off_gate: assert property ((brownout_pulse_i && !vreg_enable_i && !por_pulse_i
		&& running && !hard_rst) |=> running)
		else $error("brown-out acted with regulator off");
	a_cm_reset_flag: assert property ((running && cfg_mismatch && !power_act)
		|=> !reset_flags_o.cm && core_reset_o && cfg_reload_o)
		else $error("mismatch reset not taken");
	a_timer_starts: assert property ((state_q == rsp_pkg::ST_POWER && !power_act)
		|=> state_q == rsp_pkg::ST_TIMER && power_up_timer_cnt_q == '0 && core_reset_o)
		else $error("timer did not start cleanly");
	a_timer_holds: assert property ((state_q == rsp_pkg::ST_TIMER && !power_up_timer_done_q)
		|-> core_reset_o)
		else $error("released while timer counting");
	a_master_clear_pin_release: assert property ((state_q == rsp_pkg::ST_HOLD && master_clear_pin_i
		&& !power_act) |=> !core_reset_o ##1 $past(pc_load_o))
		else $error("no immediate start on pin release");
	a_por_flags: assert property (por_pulse_i |=> reset_flags_o == rsp_pkg::FLAGS_POR)
		else $error("power-on flags wrong");
	a_wdt_wake_pc: assert property ((wdt_wake && !hard_rst && !power_act)
		|=> wake_o && !core_reset_o && pc_value_o == $past(pc_i) + rsp_pkg::PC_STEP
		&& !reset_flags_o.to && !reset_flags_o.pd)
		else $error("watchdog wake wrong");
	a_stack_no_reset: assert property ((running && events_i.stack_underflow
		&& !stack_error_reset_enable_i && !master_clear_pin_low && !events_i.reset_instr && !wdt_rst
		&& !cfg_mismatch && !power_act) |=> reset_flags_o.stack_underflow_flag && !core_reset_o)
		else $error("underflow without enable reset the core");
	a_release_cause: assert property ($fell(core_reset_o) |-> $past(power_up_timer_done_q)
		&& $past(master_clear_pin_i) && !$past(power_act))
		else $error("released without all conditions");
	a_pin_not_driven: assert property (!master_clear_pin_oe_o [*4])
		else $error("master clear pin driven");

	c_power_up: cover property (power_up_timer_done_q ##1 !core_reset_o);
	c_bor_in_timer: cover property (state_q == rsp_pkg::ST_TIMER && bor_act);
	c_irq_vector: cover property (irq_wake && gie_any ##1 pc_load_o);
	c_mismatch: cover property (running && cfg_mismatch);
	c_wdt_wake: cover property (wdt_wake ##1 wake_o);

endmodule

// *** bench/rsp_top_tb_top.sv ***
// Self-checking testbench for the reset sequencer and power-up timer
`timescale 1ns/1ps
module rsp_top_tb_top;
	localparam int PW = 3;
	localparam int NT = 2 << PW;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic por_i = 1'b0;
	logic bo_i = 1'b0;
	logic vreg_i = 1'b1;
	logic pin_i = 1'b1;
	logic tick_i = 1'b0;
	rsp_pkg::rsp_pmode_type pm_i = rsp_pkg::PM_FULL;
	rsp_pkg::rsp_events_type ev_i = 7'h00;
	logic sten_i = 1'b0;
	logic ghi_i = 1'b0;
	logic glo_i = 1'b0;
	logic prio_i = 1'b0;
	logic [20:0] pc_i = 21'h001230;
	logic wr_i = 1'b0;
	rsp_pkg::rsp_flags_type wd_i = 8'h00;
	logic [63:0] flash_i = 64'h0123456789ABCDEF;
	logic [63:0] upset_i = 64'h0;
	logic pin_o, pin_oe, reload, core_rst, done, pc_load, wake;
	logic [63:0] words;
	rsp_pkg::rsp_flags_type flags;
	logic [20:0] pc_val;
	int error_cnt = 0;
	int cmp_count = 0;

	rsp_top #(.POWER_UP_TIMER_BITS(PW)) uut (.clk_i(clk_i), .resetn_i(resetn_i), .por_pulse_i(por_i),
		.brownout_pulse_i(bo_i), .vreg_enable_i(vreg_i), .master_clear_pin_i(pin_i),
		.master_clear_pin_o(pin_o), .master_clear_pin_oe_o(pin_oe), .internal_rc_osc_tick_i(tick_i),
		.pmode_i(pm_i), .events_i(ev_i), .stack_error_reset_enable_i(sten_i),
		.global_irq_enable_high_i(ghi_i), .global_irq_enable_low_i(glo_i),
		.irq_high_prio_i(prio_i), .pc_i(pc_i), .flag_wr_i(wr_i), .flag_wr_data_i(wd_i),
		.flash_cfg_i(flash_i), .cfg_upset_i(upset_i), .cfg_words_o(words),
		.cfg_reload_o(reload), .core_reset_o(core_rst), .power_up_timer_done_o(done),
		.reset_flags_o(flags), .pc_load_o(pc_load), .pc_value_o(pc_val), .wake_o(wake));

	initial
		forever #25 clk_i = ~clk_i;

	// RC ticks at half the bus rate so the count is not the cycle count
	always @(posedge clk_i)
		tick_i <= ~tick_i;

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: flags %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_pc(input logic [20:0] got, input logic [20:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: pc %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_run(input int lim);
		int i;
		for (i = 0; i < lim && core_rst !== 1'b0; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		if (core_rst !== 1'b0)
		begin
			error_cnt++;
			$display("mismatch at %0t: core stuck in reset", $time);
			end_of_test();
		end
		cmp_bit(pc_load, 1'b1);
		cmp_pc(pc_val, 21'h000000);
	endtask

	task automatic wr_flags(input logic [7:0] v, input logic [7:0] exp);
		@(posedge clk_i);
		wr_i <= 1'b1;
		wd_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
		#1;
		cmp_flags(flags, exp);
	endtask

	task automatic fire(input logic [6:0] e, input logic [7:0] exp, input logic rst,
		input logic ld, input logic [20:0] pcx);
		@(posedge clk_i);
		ev_i <= e;
		@(posedge clk_i);
		ev_i <= 7'h00;
		#1;
		cmp_bit(core_rst, rst);
		cmp_bit(reload, rst);
		cmp_flags(flags, exp);
		if (rst)
		begin
			@(posedge clk_i);
			#1;
			cmp_bit(core_rst, 1'b0);
		end
		cmp_bit(pc_load, ld);
		cmp_bit(wake, ld & ~rst);
		if (ld)
			cmp_pc(pc_val, pcx);
	endtask

	task automatic pin_reset(input rsp_pkg::rsp_pmode_type m, input logic [7:0] exp);
		@(posedge clk_i);
		pm_i <= m;
		pin_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		cmp_bit(core_rst, 1'b1);
		cmp_flags(flags, exp);
		@(posedge clk_i);
		pin_i <= 1'b1;
		pm_i <= rsp_pkg::PM_FULL;
		wait_run(4);
	endtask

	task automatic power_up(input logic bo, input logic [7:0] exp, input logic again,
		input logic pin);
		int n;
		@(posedge clk_i);
		por_i <= ~bo;
		bo_i <= bo;
		pin_i <= pin;
		repeat (4) @(posedge clk_i);
		#1;
		cmp_bit(core_rst, 1'b1);
		cmp_bit(done, 1'b0);
		cmp_flags(flags, exp);
		@(posedge clk_i);
		por_i <= 1'b0;
		bo_i <= 1'b0;
		if (again)
		begin
			repeat (6) @(posedge clk_i);
			bo_i <= 1'b1;
			@(posedge clk_i);
			bo_i <= 1'b0;
		end
		for (n = 0; n < 99 && done !== 1'b1; n++)
		begin
			@(posedge clk_i);
			#1;
		end
		cmp_bit(n >= NT - 1 && n <= NT + 3, 1'b1);
		cmp_bit(core_rst, 1'b1);
		if (!pin)
		begin
			repeat (4) @(posedge clk_i);
			#1;
			cmp_bit(core_rst, 1'b1);
			@(posedge clk_i);
			pin_i <= 1'b1;
		end
		wait_run(3);
		cmp_bit(pin_oe, 1'b0);
		cmp_bit(pin_o, 1'b0);
	endtask

	task automatic t_resets;
		power_up(1'b0, 8'hF0, 1'b0, 1'b1);
		wr_flags(8'hFF, 8'hFF);
		fire(7'h40, 8'hBF, 1'b1, 1'b1, 21'h0);
		wr_flags(8'hFF, 8'hFF);
		fire(7'h20, 8'hDF, 1'b1, 1'b1, 21'h0);
		pin_reset(rsp_pkg::PM_RUN, 8'hFF);
		@(posedge clk_i);
		pm_i <= rsp_pkg::PM_RUN;
		fire(7'h20, 8'hDF, 1'b1, 1'b1, 21'h0);
		pin_reset(rsp_pkg::PM_FULL, 8'hDF);
		pin_reset(rsp_pkg::PM_IDLE, 8'hEF);
	endtask

	task automatic t_wake;
		fire(7'h02, 8'hFF, 1'b0, 1'b0, 21'h0);
		@(posedge clk_i);
		pm_i <= rsp_pkg::PM_SLEEP;
		fire(7'h20, 8'hCF, 1'b0, 1'b1, 21'h001232);
		fire(7'h04, 8'hCF, 1'b0, 1'b1, 21'h001232);
		@(posedge clk_i);
		pm_i <= rsp_pkg::PM_IDLE;
		ghi_i <= 1'b1;
		prio_i <= 1'b1;
		fire(7'h04, 8'hCF, 1'b0, 1'b1, 21'h000008);
		@(posedge clk_i);
		ghi_i <= 1'b0;
		glo_i <= 1'b1;
		prio_i <= 1'b0;
		fire(7'h04, 8'hCF, 1'b0, 1'b1, 21'h000018);
		@(posedge clk_i);
		pm_i <= rsp_pkg::PM_FULL;
	endtask

	task automatic t_stack_cfg;
		int i;
		sten_i <= 1'b1;
		wr_flags(8'hFC, 8'hCC);
		fire(7'h10, 8'hCE, 1'b1, 1'b1, 21'h0);
		fire(7'h08, 8'hCF, 1'b1, 1'b1, 21'h0);
		wr_flags(8'hFC, 8'hCC);
		@(posedge clk_i);
		sten_i <= 1'b0;
		fire(7'h08, 8'hCD, 1'b0, 1'b0, 21'h0);
		// Single upset bit must be enough to trip the shadow compare
		@(posedge clk_i);
		upset_i <= 64'h0000001000000000;
		@(posedge clk_i);
		upset_i <= 64'h0;
		for (i = 0; i < 6 && core_rst !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		cmp_bit(core_rst, 1'b1);
		cmp_flags(flags, 8'h4D);
		cmp_flags(words[39:32], flash_i[39:32] ^ 8'h10);
		wait_run(4);
		// Output copy trails the store by one cycle
		@(posedge clk_i);
		#1;
		cmp_flags(words[7:0], flash_i[7:0]);
		cmp_bit(words === flash_i, 1'b1);
	endtask

	task automatic t_supply;
		// Watchdog and power-down bits are read only, so they stay low here
		wr_flags(8'hFF, 8'hCF);
		power_up(1'b1, 8'hFB, 1'b1, 1'b1);
		wr_flags(8'hFF, 8'hFF);
		@(posedge clk_i);
		vreg_i <= 1'b0;
		bo_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		bo_i <= 1'b0;
		#1;
		cmp_bit(core_rst, 1'b0);
		cmp_flags(flags, 8'hFF);
		power_up(1'b0, 8'hF0, 1'b0, 1'b0);
	endtask

	initial
	begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		#1;
		cmp_flags(flags, 8'hF0);
		cmp_bit(core_rst, 1'b1);
		t_resets();
		t_wake();
		t_stack_cfg();
		t_supply();
		end_of_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		$display("mismatch at %0t: run timed out", $time);
		end_of_test();
	end
endmodule
